// *** hw/spp_pkg.sv ***
// constants for the sequential port pointer control block
// assumes one clock; command selector values come from random-port a[2:0]
// Summary of operation
// - selected write on clock edge stores bus word; pointer moves only if enabled
// - deselected port neither reads nor writes, bus floats, pointer may advance
// - a write ends on the edge where direction or select is high
// - enabled count advances the pointer before that cycle's operation
// - load captures low twelve bus bits, pointer takes them next cycle
// - during load and the following cycle count enable is ignored
// - a jump input loads that buffer's start address in one cycle
// - read data ready one edge after jump, two edges after load
// - load and jump act regardless of select, count enable and direction
// - reset clears control state at once, without the clock
// - reset gives pointer 0, flags high, chaining, buffer one 0..4095
// - command uses address bits 2:0 and data bits 11:0 only
// - selectors 0..3 reach the four buffer limits; direction 0 writes
// - selector 4 writes or reads the flow control register
// - command write to selector 5 clears chosen end flags
// - command read of selector 5 returns flag status; 6 and 7 reserved
// - command needs command select low and chip select high
// - pointer at buffer end sets flag; chaining jumps, stop halts writes
// - zero in flag bit 0 or 1 clears that flag, one leaves it
// - a reserved selector read returns all ones
package spp_pkg;
    localparam int SPP_ADDR_W = 12;
    localparam int SPP_DATA_W = 16;
    // command selectors
    localparam logic [2:0] SPP_SEL_B1_START = 3'h0;
    localparam logic [2:0] SPP_SEL_B1_END = 3'h1;
    localparam logic [2:0] SPP_SEL_B2_START = 3'h2;
    localparam logic [2:0] SPP_SEL_B2_END = 3'h3;
    localparam logic [2:0] SPP_SEL_FLOW = 3'h4;
    localparam logic [2:0] SPP_SEL_FLAGS = 3'h5;
    // field positions
    localparam int SPP_FLOW_B1_LSB = 0;
    localparam int SPP_FLOW_B2_LSB = 2;
    localparam int SPP_FLOW_RELEASE_BIT = 4;
    localparam int SPP_FLAG_ONE_BIT = 0;
    localparam int SPP_FLAG_TWO_BIT = 1;
    // reset values
    localparam logic [11:0] SPP_PTR_RST = 12'h000;
    localparam logic [11:0] SPP_B1_START_RST = 12'h000;
    localparam logic [11:0] SPP_B1_END_RST = 12'hfff;
    localparam logic [11:0] SPP_B2_START_RST = 12'h000;
    localparam logic [11:0] SPP_B2_END_RST = 12'h000;
    localparam logic [3:0] SPP_FLOW_RST = 4'h0;
    localparam logic [15:0] SPP_RSVD_RDATA = 16'hffff;
    typedef enum logic [1:0] {
        SPP_FLOW_CHAIN = 2'b00,
        SPP_FLOW_STOP = 2'b01
    } spp_flow_t;
endpackage

// *** hw/spp_pointer_ctrl.sv ***
// sequential port pointer, buffer limits, flow modes and command access
// assumes all inputs except rst synchronous to mclk; reads of the array live elsewhere
`timescale 1ns/1ps
module spp_pointer_ctrl
    import spp_pkg::*;
#(
    parameter int ADDR_W = SPP_ADDR_W,
    parameter int DATA_W = SPP_DATA_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic seq_port_select_n,
    input wire logic count_advance_enable_n,
    input wire logic seq_direction,
    input wire logic pointer_load_n,
    input wire logic jump_start_one_n,
    input wire logic jump_start_two_n,
    input wire logic [DATA_W-1:0] seq_din,
    output logic seq_doe_n,
    output logic seq_wr_ready,
    output logic end_flag_one_n,
    output logic end_flag_two_n,
    output logic read_ready,
    output logic [ADDR_W-1:0] pointer,
    input wire logic cmd_sel_n,
    input wire logic chip_sel_n,
    input wire logic rand_rw,
    input wire logic [ADDR_W-1:0] rand_addr,
    input wire logic [DATA_W-1:0] rand_din,
    output logic [DATA_W-1:0] rand_dout,
    output logic rand_doe_n,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [ADDR_W-1:0] mem_wr_addr,
    output logic [DATA_W-1:0] mem_wr_data
);
    localparam int BW = ADDR_W + DATA_W;

    logic [ADDR_W-1:0] ptr_reg, ptr_next, stage_reg;
    logic [ADDR_W-1:0] b1_start_reg, b1_end_reg, b2_start_reg, b2_end_reg;
    logic [3:0] flow_reg;
    logic load_pend_reg, stopped_reg, read_ready_reg;
    logic end_flag_one_reg, end_flag_two_reg;
    logic [DATA_W-1:0] rand_dout_reg;
    logic rand_doe_n_reg;
    logic wr_ready;
    logic [BW-1:0] mem_word;

    // pointer control decode
    wire quiet = !load_pend_reg && pointer_load_n && jump_start_one_n
        && jump_start_two_n;
    wire wr_try = !seq_port_select_n && !seq_direction && !stopped_reg;
    wire stall = wr_try && !wr_ready;
    wire adv_req = quiet && !count_advance_enable_n && !stopped_reg && !stall;
    wire [1:0] flow1 = flow_reg[SPP_FLOW_B1_LSB +: 2];
    wire [1:0] flow2 = flow_reg[SPP_FLOW_B2_LSB +: 2];
    wire at_end1 = ptr_reg == b1_end_reg;
    wire at_end2 = ptr_reg == b2_end_reg;
    wire chain1 = at_end1 && flow1 == SPP_FLOW_CHAIN;
    wire chain2 = at_end2 && flow2 == SPP_FLOW_CHAIN;
    wire stop_hit = adv_req && ((at_end1 && flow1 == SPP_FLOW_STOP)
        || (at_end2 && flow2 == SPP_FLOW_STOP));
    // equal ends chain back to buffer one
    wire [ADDR_W-1:0] ptr_adv = chain2 ? b1_start_reg :
        chain1 ? b2_start_reg : ptr_reg + 1'b1;
    wire moved = load_pend_reg || !jump_start_one_n || !jump_start_two_n
        || adv_req;
    // load and jump ignore select, count enable and direction
    assign ptr_next = load_pend_reg ? stage_reg :
        !jump_start_one_n ? b1_start_reg :
        !jump_start_two_n ? b2_start_reg :
        adv_req ? ptr_adv : ptr_reg;

    // command decode; address bits above 2 and data above 11 ignored
    wire cmd_act = !cmd_sel_n && chip_sel_n;
    wire cmd_wr = cmd_act && !rand_rw;
    wire cmd_rd = cmd_act && rand_rw;
    wire [2:0] sel = rand_addr[2:0];
    wire [ADDR_W-1:0] cmd_val = rand_din[ADDR_W-1:0];
    wire flag_wr = cmd_wr && sel == SPP_SEL_FLAGS;
    wire clr1 = flag_wr && !rand_din[SPP_FLAG_ONE_BIT];
    wire clr2 = flag_wr && !rand_din[SPP_FLAG_TWO_BIT];
    wire set1 = moved && ptr_next == b1_end_reg;
    wire set2 = moved && ptr_next == b2_end_reg;
    wire release_wr = cmd_wr && sel == SPP_SEL_FLOW
        && !rand_din[SPP_FLOW_RELEASE_BIT];
    wire [DATA_W-ADDR_W-1:0] pad_lim = '0;
    wire [DATA_W-1:0] rd_b1s = {pad_lim, b1_start_reg};
    wire [DATA_W-1:0] rd_b1e = {pad_lim, b1_end_reg};
    wire [DATA_W-1:0] rd_b2s = {pad_lim, b2_start_reg};
    wire [DATA_W-1:0] rd_b2e = {pad_lim, b2_end_reg};
    wire [DATA_W-1:0] rd_flow = {{(DATA_W-5){1'b0}}, stopped_reg, flow_reg};
    wire [DATA_W-1:0] rd_flags = {{(DATA_W-2){1'b0}},
        !end_flag_two_reg, !end_flag_one_reg};
    // read select; reserved selectors answer all ones
    wire [DATA_W-1:0] cmd_rdata =
        sel == SPP_SEL_B1_START ? rd_b1s :
        sel == SPP_SEL_B1_END ? rd_b1e :
        sel == SPP_SEL_B2_START ? rd_b2s :
        sel == SPP_SEL_B2_END ? rd_b2e :
        sel == SPP_SEL_FLOW ? rd_flow :
        sel == SPP_SEL_FLAGS ? rd_flags :
        SPP_RSVD_RDATA[DATA_W-1:0];

    // a write takes the already advanced address when counting
    wire wr_push = wr_try && wr_ready;
    wire [ADDR_W-1:0] wr_addr = adv_req ? ptr_adv : ptr_reg;

    // stall keeps a refused word from being skipped by the pointer
    spp_wr_buffer #(
        .WIDTH(BW)
    ) u_wr_buffer (
        .mclk(mclk),
        .rst(rst),
        .in_valid(wr_push),
        .in_ready(wr_ready),
        .in_data({wr_addr, seq_din}),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data(mem_word)
    );
    assign mem_wr_addr = mem_word[BW-1:DATA_W];
    assign mem_wr_data = mem_word[DATA_W-1:0];
    assign seq_wr_ready = wr_ready;

    // pointer, staging and stop state; async clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ptr_reg <= SPP_PTR_RST[ADDR_W-1:0];
            stage_reg <= SPP_PTR_RST[ADDR_W-1:0];
            load_pend_reg <= 1'b0;
            stopped_reg <= 1'b0;
            read_ready_reg <= 1'b1;
        end else begin
            ptr_reg <= ptr_next;
            load_pend_reg <= !pointer_load_n;
            if (!pointer_load_n) begin
                stage_reg <= seq_din[ADDR_W-1:0];
            end
            // load data lags a jump by one edge
            read_ready_reg <= pointer_load_n;
            // a stop that lands in the same cycle as a release wins
            if (stop_hit) begin
                stopped_reg <= 1'b1;
            end else if (release_wr || !quiet) begin
                stopped_reg <= 1'b0;
            end
        end
    end

    // end flags, active low; hardware set wins over a clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            end_flag_one_reg <= 1'b1;
            end_flag_two_reg <= 1'b1;
        end else begin
            end_flag_one_reg <= set1 ? 1'b0 : (clr1 ? 1'b1 : end_flag_one_reg);
            end_flag_two_reg <= set2 ? 1'b0 : (clr2 ? 1'b1 : end_flag_two_reg);
        end
    end

    // buffer limits and flow modes written from the command port
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            b1_start_reg <= SPP_B1_START_RST[ADDR_W-1:0];
            b1_end_reg <= SPP_B1_END_RST[ADDR_W-1:0];
            b2_start_reg <= SPP_B2_START_RST[ADDR_W-1:0];
            b2_end_reg <= SPP_B2_END_RST[ADDR_W-1:0];
            flow_reg <= SPP_FLOW_RST;
        end else if (cmd_wr) begin
            if (sel == SPP_SEL_B1_START) b1_start_reg <= cmd_val;
            if (sel == SPP_SEL_B1_END) b1_end_reg <= cmd_val;
            if (sel == SPP_SEL_B2_START) b2_start_reg <= cmd_val;
            if (sel == SPP_SEL_B2_END) b2_end_reg <= cmd_val;
            if (sel == SPP_SEL_FLOW) flow_reg <= rand_din[3:0];
        end
    end

    // command read data and random-port drive enable (low drives)
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rand_dout_reg <= '0;
            rand_doe_n_reg <= 1'b1;
        end else begin
            rand_doe_n_reg <= !cmd_rd;
            if (cmd_rd) begin
                rand_dout_reg <= cmd_rdata;
            end
        end
    end

    // reads are handled outside, so the sequential bus never drives here
    assign seq_doe_n = 1'b1;
    assign end_flag_one_n = end_flag_one_reg;
    assign end_flag_two_n = end_flag_two_reg;
    assign read_ready = read_ready_reg;
    assign pointer = ptr_reg;
    assign rand_dout = rand_dout_reg;
    assign rand_doe_n = rand_doe_n_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_load_cycle;
        !pointer_load_n && !load_pend_reg ##1 load_pend_reg;
    endsequence
    sequence s_quiet_count;
        quiet && !count_advance_enable_n && !stopped_reg && !stall;
    endsequence

    a_load_two_step: assert property (
        s_load_cycle |=> ptr_reg == $past(stage_reg))
        else $error("pointer load did not land one cycle later");
    a_load_no_count: assert property (
        !pointer_load_n && !load_pend_reg |=> ptr_reg == $past(ptr_reg))
        else $error("pointer moved during load cycle");
    a_jump_one: assert property (
        !load_pend_reg && !jump_start_one_n |=> ptr_reg == $past(b1_start_reg))
        else $error("jump to buffer one start failed");
    a_count_step: assert property (
        s_quiet_count and !at_end1 and !at_end2
        |=> ptr_reg == $past(ptr_reg) + 1'b1)
        else $error("pointer did not advance by one");
    a_hold_still: assert property (
        quiet && count_advance_enable_n |=> $stable(ptr_reg))
        else $error("pointer moved without count enable");
    a_write_taken: assert property (
        !seq_port_select_n && !seq_direction && !stopped_reg && wr_ready
        |=> mem_wr_valid)
        else $error("selected write was not stored");
    a_write_ends: assert property (
        (seq_direction || seq_port_select_n) && !mem_wr_valid
        && !(wr_ready == 1'b0) |=> !mem_wr_valid)
        else $error("write stored while direction or select high");
    a_chain_jump: assert property (
        s_quiet_count and chain1 and !chain2
        |=> ptr_reg == $past(b2_start_reg) ##0 !end_flag_one_reg[*1])
        else $error("chaining did not jump to buffer two");
    a_flag_clear: assert property (
        clr1 && !set1 |=> end_flag_one_reg)
        else $error("end flag one not cleared");
    a_reserved_read: assert property (
        cmd_rd && sel[2:1] == 2'b11 |=> rand_dout_reg == 16'hffff)
        else $error("reserved selector read not all ones");
    a_cmd_gated: assert property (
        !chip_sel_n |=> rand_doe_n_reg)
        else $error("command answered with chip select low");
endmodule

// *** hw/spp_wr_buffer.sv ***
// two-entry write buffer between the sequential port and the memory array
// assumes the memory side may hold off with out_ready low at any time
`timescale 1ns/1ps
module spp_wr_buffer
    import spp_pkg::*;
#(
    parameter int WIDTH = 28
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic head_valid_reg;
    logic tail_valid_reg;
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] tail_reg;
    logic push;
    logic pop;

    // ready is the tail being empty, a flop, so no path from out_ready
    assign in_ready = !tail_valid_reg;
    assign out_valid = head_valid_reg;
    assign out_data = head_reg;
    assign push = in_valid && !tail_valid_reg;
    assign pop = head_valid_reg && out_ready;

    // head always holds the oldest word; tail only fills when head is busy
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            head_valid_reg <= 1'b0;
            tail_valid_reg <= 1'b0;
            head_reg <= '0;
            tail_reg <= '0;
        end else if (pop && tail_valid_reg) begin
            head_reg <= tail_reg;
            tail_valid_reg <= push;
            if (push) begin
                tail_reg <= in_data;
            end
        end else if (pop) begin
            head_valid_reg <= push;
            if (push) begin
                head_reg <= in_data;
            end
        end else if (push && !head_valid_reg) begin
            head_valid_reg <= 1'b1;
            head_reg <= in_data;
        end else if (push) begin
            tail_valid_reg <= 1'b1;
            tail_reg <= in_data;
        end
    end
endmodule

// *** testbench/spp_array_model.sv ***
// memory array model that takes words from the write buffer
// assumes the bench raises stall to hold the buffer off
`timescale 1ns/1ps
module spp_array_model
    import spp_pkg::*;
(
    input wire logic mclk,
    input wire logic stall,
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire logic [SPP_ADDR_W-1:0] mem_wr_addr,
    input wire logic [SPP_DATA_W-1:0] mem_wr_data
);
    logic [SPP_DATA_W-1:0] mem [0:4095];
    // ready drops while stalled, so the buffer has to keep its words
    assign mem_wr_ready = !stall;
    // a word lands only on a handshake edge
    always @(posedge mclk) begin
        if (mem_wr_valid && mem_wr_ready) begin
            mem[mem_wr_addr] <= mem_wr_data;
        end
    end
endmodule

// *** testbench/test_sequential_port_pointer_control.sv ***
// self-checking bench for the sequential port pointer control
// assumes a 40 MHz clock; inputs move on the falling edge, except rst, which rises 5 ns after one
`timescale 1ns/1ps
module test_sequential_port_pointer_control;
    import spp_pkg::*;
    logic mclk, rst, sel_n, cnt_n, dir, ld_n, j1_n, j2_n;
    logic cmd_n, cs_n, rw, stall, doe_n, wrdy, f1_n, f2_n;
    logic rrdy, rdoe_n, mwv, mwr;
    logic [15:0] din, rdin, rdout, mwd;
    logic [11:0] addr, ptr, mwa;
    logic [15:0] q [6];
    logic [15:0] lim [4] = '{16'h0004, 16'h0010, 16'h0200, 16'h0202};
    int n_errors, comparisons, k;
    spp_pointer_ctrl u_spp_pointer_ctrl (
        .mclk(mclk), .rst(rst), .seq_port_select_n(sel_n),
        .count_advance_enable_n(cnt_n), .seq_direction(dir),
        .pointer_load_n(ld_n), .jump_start_one_n(j1_n),
        .jump_start_two_n(j2_n), .seq_din(din), .seq_doe_n(doe_n),
        .seq_wr_ready(wrdy), .end_flag_one_n(f1_n),
        .end_flag_two_n(f2_n), .read_ready(rrdy), .pointer(ptr),
        .cmd_sel_n(cmd_n), .chip_sel_n(cs_n), .rand_rw(rw),
        .rand_addr(addr), .rand_din(rdin), .rand_dout(rdout),
        .rand_doe_n(rdoe_n), .mem_wr_valid(mwv),
        .mem_wr_ready(mwr), .mem_wr_addr(mwa), .mem_wr_data(mwd)
    );
    spp_array_model u_spp_array_model (
        .mclk(mclk), .stall(stall), .mem_wr_valid(mwv),
        .mem_wr_ready(mwr), .mem_wr_addr(mwa), .mem_wr_data(mwd)
    );
    // compare helpers, counting every check
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {15'h0, e}, {15'h0, g});
    endtask
    task automatic chkp(input logic [11:0] e);
        chk("pointer", {4'h0, e}, {4'h0, ptr});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // command accesses; a spare cycle keeps drivers from double updates
    task automatic cwr(input logic [11:0] a, input logic [15:0] d);
        cmd_n = 0;
        rw = 0;
        addr = a;
        rdin = d;
        cyc(1);
        cmd_n = 1;
        cyc(1);
    endtask
    task automatic crd(input logic [11:0] a, input logic [15:0] e);
        cmd_n = 0;
        rw = 1;
        addr = a;
        cyc(1);
        chkb("rand_doe_n", 1'h0, rdoe_n);
        chk("rand_dout", e, rdout);
        cmd_n = 1;
        rw = 0;
        cyc(1);
    endtask
    // one sequential write edge, then a deselected edge; the bench never
    // reads the sequential bus, so it is always an input here
    task automatic sw(input logic [15:0] d, input logic c);
        sel_n = 0;
        dir = 0;
        din = d;
        cnt_n = c;
        cyc(1);
        sel_n = 1;
        cnt_n = 1;
        cyc(1);
    endtask
    // deselected counting for n edges, then one idle edge
    task automatic adv(input int n);
        cnt_n = 0;
        cyc(n);
        cnt_n = 1;
        cyc(1);
    endtask
    // pointer load with count enable held low to show it is ignored
    task automatic ld(input logic [11:0] v);
        logic [11:0] p;
        p = ptr;
        ld_n = 0;
        cnt_n = 0;
        din = {4'hf, v};
        cyc(1);
        ld_n = 1;
        chkp(p);
        chkb("read_ready", 1'h0, rrdy);
        cyc(1);
        cnt_n = 1;
        chkp(v);
        chkb("read_ready", 1'h1, rrdy);
        cyc(1);
    endtask
    task automatic jmp(input logic two, input logic [11:0] e);
        j1_n = two;
        j2_n = !two;
        cyc(1);
        j1_n = 1;
        j2_n = 1;
        chkp(e);
        chkb("read_ready", 1'h1, rrdy);
        cyc(1);
    endtask
    task automatic stop_test;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // free-running clock
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    // host keeps command select high around all sequential work
    initial begin
        {rst, sel_n, cnt_n, ld_n, j1_n, j2_n, cmd_n, cs_n} = 8'hff;
        {dir, rw, stall} = 3'h0;
        din = 0;
        rdin = 0;
        addr = 0;
        n_errors = 0;
        comparisons = 0;
        cyc(2);
        rst = 0;
        chkp(12'h000);
        chkb("end_flag_one_n", 1'h1, f1_n);
        chkb("end_flag_two_n", 1'h1, f2_n);
        chkb("seq_doe_n", 1'h1, doe_n);
        crd(12'h001, 16'h0fff);
        crd(12'h004, 16'h0000);
        crd(12'h005, 16'h0000);
        crd(12'h006, 16'hffff);
        crd(12'h007, 16'hffff);
        $display("test reset_values done");
        cwr(12'hff8, 16'hf004);
        cwr(12'h001, 16'h0010);
        cwr(12'h002, 16'h0200);
        cwr(12'h003, 16'h0202);
        cwr(12'h004, 16'h0000);
        cs_n = 0;
        cwr(12'h001, 16'h0333);
        cs_n = 1;
        foreach (lim[i]) crd(12'(i), lim[i]);
        $display("test command_regs done");
        sw(16'h5678, 1'h1);
        chkp(12'h000);
        sw(16'h1234, 1'h0);
        chkp(12'h001);
        chk("mem0", 16'h5678, u_spp_array_model.mem[0]);
        chk("mem1", 16'h1234, u_spp_array_model.mem[1]);
        adv(2);
        chkp(12'h003);
        chkb("mem_wr_valid", 1'h0, mwv);
        $display("test seq_write done");
        ld(12'h00e);
        adv(2);
        chkb("end_flag_one_n", 1'h0, f1_n);
        adv(1);
        chkp(12'h200);
        adv(2);
        chkb("end_flag_two_n", 1'h0, f2_n);
        adv(1);
        chkp(12'h004);
        crd(12'h005, 16'h0003);
        cwr(12'h005, 16'h0002);
        chkb("end_flag_one_n", 1'h1, f1_n);
        chkb("end_flag_two_n", 1'h0, f2_n);
        cwr(12'h005, 16'h0001);
        chkb("end_flag_two_n", 1'h1, f2_n);
        jmp(1'h1, 12'h200);
        jmp(1'h0, 12'h004);
        $display("test chaining done");
        cwr(12'h004, 16'h0001);
        ld(12'h00f);
        adv(3);
        chkp(12'h011);
        crd(12'h004, 16'h0011);
        sw(16'hbeef, 1'h0);
        chkp(12'h011);
        chkb("mem_stop", 1'h1,
             u_spp_array_model.mem[12'h011] !== 16'hbeef);
        cwr(12'h004, 16'h0000);
        adv(1);
        chkp(12'h012);
        $display("test stop_mode done");
        // fill the buffer against a stalled array, then drain it
        stall = 1;
        sel_n = 0;
        cnt_n = 0;
        k = 0;
        for (int i = 0; i < 6; i++) begin
            din = 16'ha000 + 16'(i);
            if (wrdy === 1'b1) begin
                q[k] = din;
                k++;
            end
            cyc(1);
        end
        sel_n = 1;
        cnt_n = 1;
        stall = 0;
        chkb("seq_wr_ready", 1'h0, wrdy);
        chkb("two_taken", 1'h1, k >= 2);
        chkp(12'h012 + 12'(k));
        for (int i = 0; i < 20 && mwv !== 1'b0; i++) cyc(1);
        if (mwv !== 1'b0) begin
            n_errors++;
            $display("Error drain expected 0 seen %b", mwv);
            stop_test;
        end
        cyc(1);
        for (int j = 0; j < k; j++) begin
            chk("mem", q[j], u_spp_array_model.mem[12'h013 + 12'(j)]);
        end
        $display("test buffer_stall done");
        #5 rst = 1;
        #1 chkp(12'h000);
        chkb("end_flag_one_n", 1'h1, f1_n);
        cyc(2);
        rst = 0;
        crd(12'h001, 16'h0fff);
        crd(12'h002, 16'h0000);
        $display("test async_reset done");
        stop_test;
    end
endmodule
